/* File: core/umh_pkg.sv */
// package: register map, field positions and carrier types of the modem handshake block
package umh_pkg;

   // register byte offsets
   localparam logic [3:0] UMH_OFS_MCTL = 4'h0;
   localparam logic [3:0] UMH_OFS_MSTS = 4'h4;
   localparam int         UMH_AW       = 4;

   // modem control fields
   localparam int UMH_MCTL_TRDY  = 0;
   localparam int UMH_MCTL_RSEND = 1;
   localparam int UMH_MCTL_W     = 2;
   localparam logic [1:0] UMH_MCTL_RST = 2'h0;

   // modem status fields
   localparam int UMH_MSTS_DCTS  = 0;
   localparam int UMH_MSTS_DDSR  = 1;
   localparam int UMH_MSTS_TERI  = 2;
   localparam int UMH_MSTS_DDCD  = 3;
   localparam int UMH_MSTS_CTS   = 4;
   localparam int UMH_MSTS_DSR   = 5;
   localparam int UMH_MSTS_RING  = 6;
   localparam int UMH_MSTS_DCD   = 7;
   localparam logic [3:0] UMH_DELTA_RST = 4'h0;

   // idle level of the active-low modem pins
   localparam logic [3:0] UMH_PIN_IDLE = 4'hF;

   // axi responses
   localparam logic [1:0] UMH_RESP_OKAY   = 2'h0;
   localparam logic [1:0] UMH_RESP_SLVERR = 2'h2;

   // cycles of settling after reset before the status tracks the pins
   localparam logic [1:0] UMH_LIVE_CNT = 2'h3;

   // modem inputs, ordered as status bits 7..4
   typedef struct packed {
      logic dcd;
      logic ring;
      logic dsr;
      logic cts;
   } umh_modem_t;

endpackage

/* File: core/umh_sync2.sv */
// two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/10ps
`default_nettype none
module umh_sync2 #(
   parameter int         WIDTH   = 4,
   parameter logic [3:0] RST_VAL = 4'hF
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_resetn,
   input  wire logic [WIDTH-1:0] i_d,
   output var  logic [WIDTH-1:0] o_q
);

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic meta_r;
         always_ff @(posedge i_ref_clk) begin
            if (!i_resetn) begin
               meta_r <= RST_VAL[g];
               o_q[g] <= RST_VAL[g];
            end else begin
               meta_r <= i_d[g];
               o_q[g] <= meta_r;
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

/* File: core/umh_top.sv */
// modem handshake pins of the uart with axi4-lite register access
`timescale 1ns/10ps
`default_nettype none
module umh_top
   import umh_pkg::*;
(
   input  wire logic             i_ref_clk,
   input  wire logic             i_resetn,
   // axi4-lite slave
   input  wire logic [31:0]      s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output var  logic             s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output var  logic             s_axi_wready,
   output var  logic [1:0]       s_axi_bresp,
   output var  logic             s_axi_bvalid,
   input  wire logic             s_axi_bready,
   input  wire logic [31:0]      s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output var  logic             s_axi_arready,
   output var  logic [31:0]      s_axi_rdata,
   output var  logic [1:0]       s_axi_rresp,
   output var  logic             s_axi_rvalid,
   input  wire logic             s_axi_rready,
   // modem pins, active low
   input  wire umh_modem_t       i_modem_n,
   output var  logic             o_term_rdy_n,
   output var  logic             o_req_send_n
);

   // ---------------- modem inputs ----------------
   umh_modem_t                   sync_n;
   umh_modem_t                   asrt;
   umh_modem_t                   asrt_prev_r;
   logic [3:0]                   delta_r;
   logic [3:0]                   delta_evt;
   logic [3:0]                   delta_clr;
   logic [7:0]                   msts;

   umh_sync2 #(
      .WIDTH   (4),
      .RST_VAL (UMH_PIN_IDLE)
   ) u_sync (
      .i_ref_clk (i_ref_clk),
      .i_resetn  (i_resetn),
      .i_d       (i_modem_n),
      .o_q       (sync_n)
   );

   assign asrt = ~sync_n;

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         asrt_prev_r <= ~UMH_PIN_IDLE;
      end else begin
         asrt_prev_r <= asrt;
      end
   end

   // change flags; ring flag on trailing edge only
   assign delta_evt[UMH_MSTS_DCTS] = asrt.cts ^ asrt_prev_r.cts;
   assign delta_evt[UMH_MSTS_DDSR] = asrt.dsr ^ asrt_prev_r.dsr;
   assign delta_evt[UMH_MSTS_TERI] = asrt_prev_r.ring & ~asrt.ring;
   assign delta_evt[UMH_MSTS_DDCD] = asrt.dcd ^ asrt_prev_r.dcd;

   // sticky flags; a new event wins over the clear of a read
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         delta_r <= UMH_DELTA_RST;
      end else begin
         delta_r <= (delta_r & ~delta_clr) | delta_evt;
      end
   end

   assign msts = {asrt.dcd, asrt.ring, asrt.dsr, asrt.cts, delta_r};

   // ---------------- modem control ----------------
   logic [UMH_MCTL_W-1:0]        mctl_r;
   logic                         wr_fire;
   logic                         wr_hit;
   logic [UMH_AW-1:0]            awaddr_r;
   logic [31:0]                  wdata_r;
   logic [3:0]                   wstrb_r;

   assign wr_hit = wr_fire && (awaddr_r == UMH_OFS_MCTL);

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         mctl_r <= UMH_MCTL_RST;
      end else if (wr_hit && wstrb_r[0]) begin
         mctl_r <= wdata_r[UMH_MCTL_W-1:0];
      end
   end

   // pins asserted low when the control bit is set
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         o_term_rdy_n <= 1'b1;
         o_req_send_n <= 1'b1;
      end else begin
         o_term_rdy_n <= ~mctl_r[UMH_MCTL_TRDY];
         o_req_send_n <= ~mctl_r[UMH_MCTL_RSEND];
      end
   end

   // ---------------- axi write channel ----------------
   logic                         aw_held_r;
   logic                         w_held_r;
   logic                         aw_held_nxt;
   logic                         w_held_nxt;
   logic                         aw_fire;
   logic                         w_fire;

   assign aw_fire = s_axi_awvalid && s_axi_awready;
   assign w_fire  = s_axi_wvalid && s_axi_wready;
   assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

   always_comb begin
      aw_held_nxt = aw_held_r;
      w_held_nxt  = w_held_r;
      if (wr_fire) begin
         aw_held_nxt = 1'b0;
         w_held_nxt  = 1'b0;
      end
      if (aw_fire) begin
         aw_held_nxt = 1'b1;
      end
      if (w_fire) begin
         w_held_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         aw_held_r     <= 1'b0;
         w_held_r      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         aw_held_r     <= aw_held_nxt;
         w_held_r      <= w_held_nxt;
         s_axi_awready <= !aw_held_nxt;
         s_axi_wready  <= !w_held_nxt;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         awaddr_r <= '0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
      end else begin
         if (aw_fire) begin
            awaddr_r <= s_axi_awaddr[UMH_AW-1:0];
         end
         if (w_fire) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
      end
   end

   // status register is read only; a write there is accepted and dropped
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= UMH_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wr_hit || awaddr_r == UMH_OFS_MSTS) ? UMH_RESP_OKAY : UMH_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ---------------- axi read channel ----------------
   logic                         ar_fire;
   logic                         rvalid_nxt;
   logic [UMH_AW-1:0]            rd_addr;

   assign ar_fire    = s_axi_arvalid && s_axi_arready;
   assign rvalid_nxt = ar_fire || (s_axi_rvalid && !s_axi_rready);
   assign rd_addr    = s_axi_araddr[UMH_AW-1:0];
   assign delta_clr  = (ar_fire && rd_addr == UMH_OFS_MSTS) ? 4'hF : 4'h0;

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
      end else begin
         s_axi_arready <= !rvalid_nxt;
         s_axi_rvalid  <= rvalid_nxt;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         s_axi_rdata <= '0;
         s_axi_rresp <= UMH_RESP_OKAY;
      end else if (ar_fire) begin
         case (rd_addr)
            UMH_OFS_MCTL: begin
               s_axi_rdata <= {30'h0, mctl_r};
               s_axi_rresp <= UMH_RESP_OKAY;
            end
            UMH_OFS_MSTS: begin
               s_axi_rdata <= {24'h0, msts};
               s_axi_rresp <= UMH_RESP_OKAY;
            end
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= UMH_RESP_SLVERR;
            end
         endcase
      end
   end

   // ---------------- checks ----------------
   logic [1:0]                   live_r;

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         live_r <= '0;
      end else if (live_r != UMH_LIVE_CNT) begin
         live_r <= live_r + 2'h1;
      end
   end

   AST_CTS_BIT: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (live_r == UMH_LIVE_CNT) |-> msts[UMH_MSTS_CTS] == !$past(i_modem_n.cts, 2))
      else $error("cts status bit does not follow pin");

   AST_DSR_BIT: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (live_r == UMH_LIVE_CNT) && !i_modem_n.dsr |-> ##2 msts[UMH_MSTS_DSR])
      else $error("dsr status bit not set two cycles after pin low");

   AST_DSR_CLR: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (live_r == UMH_LIVE_CNT) && i_modem_n.dsr |-> ##2 !msts[UMH_MSTS_DSR])
      else $error("dsr status bit not clear two cycles after pin high");

   AST_RING_BIT: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (live_r == UMH_LIVE_CNT) && i_modem_n.ring |-> ##2 !msts[UMH_MSTS_RING])
      else $error("ring status bit not clear two cycles after pin high");

   AST_RING_SET: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (live_r == UMH_LIVE_CNT) && !i_modem_n.ring |-> ##2 msts[UMH_MSTS_RING])
      else $error("ring status bit not set two cycles after pin low");

   AST_DCD_BIT: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      $fell(i_modem_n.dcd) && (live_r == UMH_LIVE_CNT) |-> ##1 !msts[UMH_MSTS_DCD] ##1 msts[UMH_MSTS_DCD])
      else $error("dcd status bit timing wrong");

   AST_DCD_CLR: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (live_r == UMH_LIVE_CNT) && i_modem_n.dcd |-> ##2 !msts[UMH_MSTS_DCD])
      else $error("dcd status bit not clear two cycles after pin high");

   AST_STS_READ: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (live_r == UMH_LIVE_CNT) && ar_fire && rd_addr == UMH_OFS_MSTS
      |=> s_axi_rdata[UMH_MSTS_DCD:UMH_MSTS_CTS] == ~$past(i_modem_n, 3))
      else $error("status read does not show asserted pins");

   AST_TRDY_PIN: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (live_r != 2'h0) |-> o_term_rdy_n == !$past(mctl_r[UMH_MCTL_TRDY]))
      else $error("terminal ready pin does not follow control bit 0");

   AST_RSEND_PIN: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      wr_hit && wstrb_r[0] |-> ##2 o_req_send_n == !$past(wdata_r[UMH_MCTL_RSEND], 2))
      else $error("request to send pin does not follow written bit 1");

   AST_CTL_READ: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      ar_fire && rd_addr == UMH_OFS_MCTL |=> s_axi_rdata[UMH_MCTL_W-1:0] == ~{o_req_send_n, o_term_rdy_n})
      else $error("control read does not match the modem output pins");

   AST_PINS_RESET: assert property (@(posedge i_ref_clk)
      !i_resetn |=> o_term_rdy_n && o_req_send_n)
      else $error("modem output pins not deasserted after reset");

   AST_SYNC_DEPTH: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (live_r == UMH_LIVE_CNT) && $changed(sync_n) |-> sync_n == $past(i_modem_n, 2))
      else $error("synchroniser output not two stages behind pin");

   COV_WRITE_CTRL: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
      wr_hit ##2 !o_term_rdy_n && !o_req_send_n);

   COV_READ_STS: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
      ar_fire && rd_addr == UMH_OFS_MSTS && delta_r != 4'h0);

   COV_RING_TRAIL: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
      delta_evt[UMH_MSTS_TERI]);

   COV_SET_CLR: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
      |(delta_evt & delta_clr));

endmodule
`default_nettype wire

/* File: verif/umh_modem_model.sv */
// behavioural modem that drives the active-low handshake pins of the uart
`timescale 1ns/10ps
`default_nettype none
module umh_modem_model
   import umh_pkg::*;
(
   input  wire logic       i_ref_clk,
   input  wire logic [3:0] i_assert,
   input  wire logic       i_term_rdy_n,
   input  wire logic       i_req_send_n,
   output var  umh_modem_t o_modem_n,
   output var  logic [1:0] o_seen
);
   // pins are active low: an asserted condition pulls its pin low
   always_comb begin
      o_modem_n = umh_modem_t'(~i_assert);
   end
   // what the modem sees of terminal-ready and request-to-send, active high
   always_ff @(posedge i_ref_clk) begin
      o_seen <= {~i_req_send_n, ~i_term_rdy_n};
   end
endmodule
`default_nettype wire

/* File: verif/umh_top_tb.sv */
// self-checking bench of the modem handshake block
`timescale 1ns/10ps
`default_nettype none
module umh_top_tb
   import umh_pkg::*;
;
   logic        i_ref_clk, i_resetn;
   logic [31:0] awaddr, wdata, araddr, rdata, d;
   logic [3:0]  wstrb, assert_v;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, term_n, rts_n;
   logic [1:0]  bresp, rresp, r, seen;
   umh_modem_t  modem_n;
   int          err_total, samples_checked;

   umh_top umh_top_i (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .i_modem_n(modem_n), .o_term_rdy_n(term_n), .o_req_send_n(rts_n));
   umh_modem_model umh_modem_model_i (.i_ref_clk(i_ref_clk), .i_assert(assert_v),
      .i_term_rdy_n(term_n), .i_req_send_n(rts_n), .o_modem_n(modem_n), .o_seen(seen));

   initial begin
      i_ref_clk = 1'b0;
      forever #2 i_ref_clk = ~i_ref_clk;
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s);
      int   n;
      logic got;
      n   = 0;
      got = 1'b0;
      @(posedge i_ref_clk);
      awaddr  <= a;
      wdata   <= v;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!got && n < 50) begin
         @(posedge i_ref_clk);
         n++;
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            r   = bresp;
            got = 1'b1;
            bready <= 1'b0;
         end
      end
      if (!got) chk(32'h0, 32'h1);
   endtask

   task automatic axi_rd(input logic [31:0] a);
      int   n;
      logic got;
      n   = 0;
      got = 1'b0;
      @(posedge i_ref_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!got && n < 50) begin
         @(posedge i_ref_clk);
         n++;
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d   = rdata;
            r   = rresp;
            got = 1'b1;
            rready <= 1'b0;
         end
      end
      if (!got) chk(32'h0, 32'h1);
   endtask

   initial begin
      #80000;
      err_total++;
      end_sim();
   end

   initial begin
      logic [1:0]  v;
      logic [15:0] dexp;
      dexp     = 16'hC231;
      i_resetn = 1'b0;
      {awaddr, wdata, araddr} = '0;
      {wstrb, assert_v} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      repeat (3) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      chk({30'h0, rts_n, term_n}, 32'h3);
      axi_rd({28'h0, UMH_OFS_MCTL});
      chk(d, 32'h0);
      axi_rd({28'h0, UMH_OFS_MSTS});
      chk(d, 32'h0);
      $display("test reset done");
      for (int k = 0; k < 4; k++) begin
         v = 2'((k * 3 + 1) % 4);
         axi_wr({28'h0, UMH_OFS_MCTL}, {30'h0, v}, 4'hF);
         chk({30'h0, r}, {30'h0, UMH_RESP_OKAY});
         repeat (2) @(posedge i_ref_clk);
         chk({30'h0, rts_n, term_n}, {30'h0, ~v});
         chk({30'h0, seen}, {30'h0, v});
         axi_rd({28'h0, UMH_OFS_MCTL});
         chk(d, {30'h0, v});
      end
      axi_wr({28'h0, UMH_OFS_MCTL}, 32'h0, 4'h0);
      chk({30'h0, r}, {30'h0, UMH_RESP_OKAY});
      repeat (2) @(posedge i_ref_clk);
      chk({30'h0, rts_n, term_n}, {30'h0, ~v});
      axi_wr(32'h8, 32'h3, 4'hF);
      chk({30'h0, r}, {30'h0, UMH_RESP_SLVERR});
      repeat (2) @(posedge i_ref_clk);
      chk({30'h0, rts_n, term_n}, {30'h0, ~v});
      axi_rd(32'hC);
      chk({d[29:0], r}, {30'h0, UMH_RESP_SLVERR});
      $display("test control done");
      for (int i = 0; i < 4; i++) begin
         @(posedge i_ref_clk);
         assert_v <= 4'h1 << i;
         repeat (4) @(posedge i_ref_clk);
         axi_rd({28'h0, UMH_OFS_MSTS});
         chk(d & 32'hF0, 32'h10 << i);
         chk(d & 32'hF, {28'h0, dexp[4 * i +: 4]});
      end
      @(posedge i_ref_clk);
      assert_v <= 4'h0;
      repeat (4) @(posedge i_ref_clk);
      axi_rd({28'h0, UMH_OFS_MSTS});
      chk(d & 32'hF0, 32'h0);
      chk(d & 32'hF, 32'h8);
      $display("test status done");
      @(posedge i_ref_clk);
      assert_v <= 4'h1;
      axi_rd({28'h0, UMH_OFS_MSTS});
      chk(d & 32'h10, 32'h0);
      axi_rd({28'h0, UMH_OFS_MSTS});
      chk(d & 32'h10, 32'h10);
      $display("test sync done");
      i_resetn <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      chk({30'h0, rts_n, term_n}, 32'h3);
      axi_rd({28'h0, UMH_OFS_MCTL});
      chk(d, 32'h0);
      axi_rd({28'h0, UMH_OFS_MSTS});
      chk(d & 32'hF0, 32'h10);
      $display("test reset again done");
      end_sim();
   end
endmodule
`default_nettype wire
